// ### mlp_pkg.sv
// Constants, types and encodings for the multiply, logic and prefetch execution slice.
// Assumes a decoder that presents one 32-bit instruction word per cycle with a valid bit.
// How it works
// - Upper-move copies source_a into upper product register only when source_b, dest and shift fields are all zero
// - Bottom-move copies source_a into bottom product register
// - Product-to-dest writes signed low word to dest
// - Signed product fills bottom and upper registers
// - Unsigned product fills bottom and upper registers
// - Multiplies never raise overflow exceptions
// - All-zero word shifts register zero, changes nothing
// - NOR of two sources to destination
// - OR of two sources to destination
// - Zero-extended immediate OR source_a into source_b
// - Prefetch address is base plus signed offset
// - Prefetch never changes architectural state
// - Bad prefetch address: no exception, no data
// - No bus read for uncached prefetch address
// - Bus read uses address's own access type
// - Listed conditions turn prefetch into idle
// - Otherwise prefetch starts external bus read
// - Pipeline never stalls on prefetch data
// - Hint 0 load, 1 store, 2-3 reserved
package mlp_pkg;
    localparam int XLEN = 32;
    localparam int REG_AW = 5;
    localparam int CCA_W = 3;
    localparam int HINT_W = 5;

    // Primary and function codes
    localparam logic [5:0] OPC_SPECIAL = 6'h00;
    localparam logic [5:0] OPC_SECONDARY_GROUP = 6'h1c;
    localparam logic [5:0] OPC_EITHER_IMMEDIATE = 6'h0d;
    localparam logic [5:0] OPC_CACHE_WARM = 6'h33;
    localparam logic [5:0] FN_SHIFT_LEFT_LOGICAL = 6'h00;
    localparam logic [5:0] FN_WRITE_UPPER = 6'h11;
    localparam logic [5:0] FN_WRITE_BOTTOM = 6'h13;
    localparam logic [5:0] FN_SIGNED_PRODUCT = 6'h18;
    localparam logic [5:0] FN_UNSIGNED_PRODUCT = 6'h19;
    localparam logic [5:0] FN_EITHER = 6'h25;
    localparam logic [5:0] FN_NEITHER = 6'h27;
    localparam logic [5:0] FN_PRODUCT_TO_DEST = 6'h02;

    // Hint values
    localparam logic [4:0] HINT_LOAD = 5'h00;
    localparam logic [4:0] HINT_STORE = 5'h01;
    localparam logic [4:0] HINT_STREAM_FIRST = 5'h04;
    localparam logic [4:0] HINT_RETAIN_LAST = 5'h07;
    localparam logic [4:0] HINT_WRITEBACK_INV = 5'h19;

    localparam logic [4:0] REG_ZERO = 5'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // Instruction word split into its fields
    typedef struct packed {
        logic [5:0] op;
        logic [4:0] src_a;
        logic [4:0] src_b;
        logic [4:0] dest;
        logic [4:0] shamt;
        logic [5:0] fn;
    } mlp_instr_t;

    // Result heading for the general register file
    typedef struct packed {
        logic valid;
        logic [REG_AW-1:0] dest;
        logic [XLEN-1:0] data;
    } mlp_wb_t;

    // Translation request and answer
    typedef struct packed {
        logic valid;
        logic [XLEN-1:0] vaddr;
    } mlp_xlat_req_t;

    typedef struct packed {
        logic ok;
        logic uncached;
        logic cache_hit;
        logic [CCA_W-1:0] cca;
        logic [XLEN-1:0] paddr;
    } mlp_xlat_rsp_t;

    // External bus read request
    typedef struct packed {
        logic req;
        logic for_store;
        logic [CCA_W-1:0] cca;
        logic [XLEN-1:0] addr;
    } mlp_bus_req_t;

    // Bus read tracker, Gray along idle, request, wait
    typedef enum logic [1:0] {
        MLP_BUS_IDLE = 2'b00,
        MLP_BUS_REQ = 2'b01,
        MLP_BUS_WAIT = 2'b11
    } mlp_bus_state_t;
endpackage : mlp_pkg

// ### mlp_regfile.sv
// General register file: two read ports with registered data, one write port.
// Assumes the caller forwards a write that lands on the same edge as a read.
`timescale 1ns/1ps
module mlp_regfile #(
    parameter int DEPTH = 32,
    parameter int AW = 5,
    parameter int DW = 32
) (
    // Clock
    input wire logic clk,
    // Read ports
    input wire logic [AW-1:0] rd_addr_a,
    input wire logic [AW-1:0] rd_addr_b,
    output logic [DW-1:0] rd_data_a,
    output logic [DW-1:0] rd_data_b,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data
);
    import mlp_pkg::*;

    logic [DW-1:0] mem [DEPTH];

    // Storage is not reset; register zero is masked on read instead
    always_ff @(posedge clk) begin
        if (wr_en && wr_addr != REG_ZERO) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_a <= (rd_addr_a == REG_ZERO) ? WORD_ZERO : mem[rd_addr_a];
        rd_data_b <= (rd_addr_b == REG_ZERO) ? WORD_ZERO : mem[rd_addr_b];
    end
endmodule : mlp_regfile

// ### mlp_exec.sv
// Execute slice: product pair moves, multiplies, logic ops and the prefetch path.
// Assumes translation answers in the cycle its request is shown, and the bus
// acknowledges a read request and later signals its data returned.
`timescale 1ns/1ps
module mlp_exec (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Instruction issue
    input wire logic instr_valid,
    input wire mlp_pkg::mlp_instr_t instr,
    // Writeback and product pair
    output mlp_pkg::mlp_wb_t wb,
    output logic [mlp_pkg::XLEN-1:0] upper_product_reg,
    output logic [mlp_pkg::XLEN-1:0] bottom_product_reg,
    // Address translation
    output mlp_pkg::mlp_xlat_req_t xlat_req,
    input wire mlp_pkg::mlp_xlat_rsp_t xlat_rsp,
    // External bus read
    input wire logic load_pending,
    input wire logic bus_ack,
    input wire logic bus_done,
    output mlp_pkg::mlp_bus_req_t bus_req
);
    import mlp_pkg::*;

    // Whole module state
    typedef struct packed {
        logic s1_valid;
        mlp_instr_t s1_instr;
        mlp_wb_t wb;
        logic [XLEN-1:0] upper;
        logic [XLEN-1:0] bottom;
        mlp_xlat_req_t xlat;
        logic [HINT_W-1:0] pf_hint;
        mlp_bus_state_t bus_st;
        mlp_bus_req_t bus;
    } mlp_state_t;

    mlp_state_t st_q;
    mlp_state_t st_d;
    logic [XLEN-1:0] rdata_a;
    logic [XLEN-1:0] rdata_b;
    logic [XLEN-1:0] op_a;
    logic [XLEN-1:0] op_b;
    logic [2*XLEN-1:0] prod_s;
    logic [2*XLEN-1:0] prod_u;
    logic rf_we;
    logic [REG_AW-1:0] rf_waddr;
    logic [XLEN-1:0] rf_wdata;
    logic pf_fetch;
    logic bus_free;
    logic [15:0] imm16;

    // 64-bit product, signed or zero-extended operands
    function automatic logic [2*XLEN-1:0] mlp_mul64(input logic [XLEN-1:0] a,
                                                     input logic [XLEN-1:0] b,
                                                     input logic sgn);
        logic [2*XLEN-1:0] ea;
        logic [2*XLEN-1:0] eb;
        ea = sgn ? {{XLEN{a[XLEN-1]}}, a} : {{XLEN{1'b0}}, a};
        eb = sgn ? {{XLEN{b[XLEN-1]}}, b} : {{XLEN{1'b0}}, b};
        return ea * eb;
    endfunction : mlp_mul64

    // Immediate field of an I-type word
    function automatic logic [15:0] mlp_imm16(input mlp_instr_t i);
        return {i.dest, i.shamt, i.fn};
    endfunction : mlp_imm16

    // Hints that fetch data; every other value is reserved or idle
    function automatic logic mlp_hint_fetches(input logic [HINT_W-1:0] h);
        return (h == HINT_LOAD) || (h == HINT_STORE) ||
               (h >= HINT_STREAM_FIRST && h <= HINT_RETAIN_LAST);
    endfunction : mlp_hint_fetches

    mlp_regfile #(
        .DEPTH(1 << REG_AW),
        .AW(REG_AW),
        .DW(XLEN)
    ) u_rf (
        .clk(clk),
        .rd_addr_a(instr.src_a),
        .rd_addr_b(instr.src_b),
        .rd_data_a(rdata_a),
        .rd_data_b(rdata_b),
        .wr_en(rf_we),
        .wr_addr(rf_waddr),
        .wr_data(rf_wdata)
    );

    // Forward last cycle's write; the file returned the old word for it
    always_comb begin
        op_a = rdata_a;
        op_b = rdata_b;
        if (st_q.wb.valid && st_q.wb.dest == st_q.s1_instr.src_a) begin
            op_a = st_q.wb.data;
        end
        if (st_q.wb.valid && st_q.wb.dest == st_q.s1_instr.src_b) begin
            op_b = st_q.wb.data;
        end
        if (st_q.s1_instr.src_a == REG_ZERO) begin
            op_a = WORD_ZERO;
        end
        if (st_q.s1_instr.src_b == REG_ZERO) begin
            op_b = WORD_ZERO;
        end
    end

    // Immediate of the executing word, named so its sign bit can be picked
    assign imm16 = mlp_imm16(st_q.s1_instr);

    assign prod_s = mlp_mul64(op_a, op_b, 1'b1);
    assign prod_u = mlp_mul64(op_a, op_b, 1'b0);

    // Prefetch decision on the translation answer
    assign bus_free = (st_q.bus_st == MLP_BUS_IDLE) && !load_pending;
    assign pf_fetch = st_q.xlat.valid && mlp_hint_fetches(st_q.pf_hint) &&
                      st_q.pf_hint != HINT_WRITEBACK_INV &&
                      xlat_rsp.ok && !xlat_rsp.uncached &&
                      !xlat_rsp.cache_hit && bus_free;

    // Next state
    always_comb begin
        st_d = st_q;
        rf_we = 1'b0;
        rf_waddr = st_q.s1_instr.dest;
        rf_wdata = WORD_ZERO;
        // Issue never waits, so a pending prefetch cannot hold up the stream
        st_d.s1_valid = instr_valid;
        st_d.s1_instr = instr;
        st_d.wb.valid = 1'b0;
        st_d.xlat.valid = 1'b0;
        if (st_q.s1_valid) begin
            case (st_q.s1_instr.op)
                OPC_SPECIAL: begin
                    case (st_q.s1_instr.fn)
                        FN_SHIFT_LEFT_LOGICAL: begin
                            // Zero word lands on register zero and is dropped
                            rf_we = 1'b1;
                            rf_wdata = op_b << st_q.s1_instr.shamt;
                        end
                        FN_WRITE_UPPER: begin
                            if ({st_q.s1_instr.src_b, st_q.s1_instr.dest,
                                 st_q.s1_instr.shamt} == 15'h0000) begin
                                st_d.upper = op_a;
                            end
                        end
                        FN_WRITE_BOTTOM: begin
                            st_d.bottom = op_a;
                        end
                        FN_SIGNED_PRODUCT: begin
                            // Overwrites any unread result; ordering is software's job
                            st_d.bottom = prod_s[XLEN-1:0];
                            st_d.upper = prod_s[2*XLEN-1:XLEN];
                        end
                        FN_UNSIGNED_PRODUCT: begin
                            st_d.bottom = prod_u[XLEN-1:0];
                            st_d.upper = prod_u[2*XLEN-1:XLEN];
                        end
                        FN_EITHER: begin
                            rf_we = 1'b1;
                            rf_wdata = op_a | op_b;
                        end
                        FN_NEITHER: begin
                            rf_we = 1'b1;
                            rf_wdata = ~(op_a | op_b);
                        end
                        default: begin
                        end
                    endcase
                end
                OPC_SECONDARY_GROUP: begin
                    if (st_q.s1_instr.fn == FN_PRODUCT_TO_DEST) begin
                        // Pair left as it was, which the undefined result allows
                        rf_we = 1'b1;
                        rf_wdata = prod_s[XLEN-1:0];
                    end
                end
                OPC_EITHER_IMMEDIATE: begin
                    rf_we = 1'b1;
                    rf_waddr = st_q.s1_instr.src_b;
                    rf_wdata = op_a | {16'h0000, mlp_imm16(st_q.s1_instr)};
                end
                OPC_CACHE_WARM: begin
                    // Only a translation and maybe a bus read; no register touched
                    st_d.xlat.valid = 1'b1;
                    st_d.xlat.vaddr = op_a + {{16{imm16[15]}}, imm16};
                    st_d.pf_hint = st_q.s1_instr.src_b;
                end
                default: begin
                end
            endcase
        end
        // No overflow path exists for any multiply
        if (rf_we && rf_waddr != REG_ZERO) begin
            st_d.wb.valid = 1'b1;
            st_d.wb.dest = rf_waddr;
            st_d.wb.data = rf_wdata;
        end
        // Bus read tracker; one prefetch in flight at a time
        case (st_q.bus_st)
            MLP_BUS_IDLE: begin
                if (pf_fetch) begin
                    st_d.bus_st = MLP_BUS_REQ;
                    st_d.bus.req = 1'b1;
                    st_d.bus.addr = xlat_rsp.paddr;
                    st_d.bus.cca = xlat_rsp.cca;
                    st_d.bus.for_store = st_q.pf_hint[0];
                end
            end
            MLP_BUS_REQ: begin
                if (bus_ack) begin
                    st_d.bus.req = 1'b0;
                    st_d.bus_st = bus_done ? MLP_BUS_IDLE : MLP_BUS_WAIT;
                end
            end
            MLP_BUS_WAIT: begin
                if (bus_done) begin
                    st_d.bus_st = MLP_BUS_IDLE;
                end
            end
            default: begin
                st_d.bus_st = MLP_BUS_IDLE;
                st_d.bus.req = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
            st_q.bus_st <= MLP_BUS_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign wb = st_q.wb;
    assign upper_product_reg = st_q.upper;
    assign bottom_product_reg = st_q.bottom;
    assign xlat_req = st_q.xlat;
    assign bus_req = st_q.bus;

    // Decoded conditions used by the checks
    logic chk_special;
    assign chk_special = st_q.s1_valid && st_q.s1_instr.op == OPC_SPECIAL;

    sequence s_pf_seen;
        st_q.xlat.valid && mlp_hint_fetches(st_q.pf_hint) &&
            st_q.pf_hint != HINT_WRITEBACK_INV;
    endsequence

    sequence s_pf_good;
        xlat_rsp.ok && !xlat_rsp.uncached && !xlat_rsp.cache_hit && bus_free;
    endsequence

    a_upper_move: assert property (@(posedge clk) disable iff (rst)
        chk_special && st_q.s1_instr.fn == FN_WRITE_UPPER &&
        {st_q.s1_instr.src_b, st_q.s1_instr.dest, st_q.s1_instr.shamt} == 15'h0000
        |=> upper_product_reg == $past(op_a))
        else $error("upper move wrong");

    a_bottom_move: assert property (@(posedge clk) disable iff (rst)
        chk_special && st_q.s1_instr.fn == FN_WRITE_BOTTOM
        |=> bottom_product_reg == $past(op_a) && $stable(upper_product_reg))
        else $error("bottom move wrong");

    a_signed_pair: assert property (@(posedge clk) disable iff (rst)
        chk_special && st_q.s1_instr.fn == FN_SIGNED_PRODUCT
        |=> $signed({upper_product_reg, bottom_product_reg}) ==
            $signed($past(op_a)) * $signed($past(op_b)))
        else $error("signed product wrong");

    a_unsigned_pair: assert property (@(posedge clk) disable iff (rst)
        chk_special && st_q.s1_instr.fn == FN_UNSIGNED_PRODUCT
        |=> {upper_product_reg, bottom_product_reg} ==
            {32'h0000_0000, $past(op_a)} * {32'h0000_0000, $past(op_b)})
        else $error("unsigned product wrong");

    a_neither_result: assert property (@(posedge clk) disable iff (rst)
        chk_special && st_q.s1_instr.fn == FN_NEITHER && st_q.s1_instr.dest != REG_ZERO
        |=> wb.valid && wb.data == ~($past(op_a) | $past(op_b)))
        else $error("nor result wrong");

    a_zero_dest: assert property (@(posedge clk) disable iff (rst)
        wb.valid |-> wb.dest != REG_ZERO)
        else $error("write to register zero");

    a_pf_issue: assert property (@(posedge clk) disable iff (rst)
        s_pf_seen ##0 s_pf_good |=> bus_req.req && bus_req.addr == $past(xlat_rsp.paddr)
            && bus_req.cca == $past(xlat_rsp.cca))
        else $error("prefetch read not issued");

    a_pf_drop: assert property (@(posedge clk) disable iff (rst)
        st_q.xlat.valid && (xlat_rsp.uncached || !xlat_rsp.ok) && !bus_req.req
        |=> !bus_req.req)
        else $error("dropped prefetch reached bus");

    a_req_hold: assert property (@(posedge clk) disable iff (rst)
        bus_req.req && !bus_ack |=> bus_req.req && $stable(bus_req.addr))
        else $error("bus request not held");

    a_pf_no_wb: assert property (@(posedge clk) disable iff (rst)
        st_q.s1_valid && st_q.s1_instr.op == OPC_CACHE_WARM |=> !wb.valid)
        else $error("prefetch wrote a register");
endmodule : mlp_exec

// ### mlp_far_model.sv
// Far side of the execute slice: address translation and external read bus.
// Assumes the bench sets the translation answer and the acknowledge delay.
`timescale 1ns/1ps
module mlp_far_model #(
    parameter logic [31:0] PHYS_XOR = 32'h2000_0000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Settings from the bench
    input wire logic cfg_ok,
    input wire logic cfg_uncached,
    input wire logic cfg_hit,
    input wire logic [2:0] cfg_cca,
    input wire logic [3:0] ack_dly,
    // Design side
    input wire mlp_pkg::mlp_xlat_req_t xlat_req,
    output mlp_pkg::mlp_xlat_rsp_t xlat_rsp,
    input wire mlp_pkg::mlp_bus_req_t bus_req,
    output logic bus_ack,
    output logic bus_done,
    // Observed reads
    output logic [7:0] n_reads,
    output mlp_pkg::mlp_bus_req_t last_req
);
    import mlp_pkg::*;
    logic tog_q;
    logic [3:0] cnt_q;
    logic [3:0] done_cnt_q;

    // Answer only while asked; otherwise a pattern that flips each cycle
    always_comb begin
        if (xlat_req.valid) begin
            xlat_rsp = {cfg_ok, cfg_uncached, cfg_hit, cfg_cca, xlat_req.vaddr ^ PHYS_XOR};
        end else begin
            xlat_rsp = {$bits(mlp_xlat_rsp_t){tog_q}};
        end
    end

    // Acknowledge after ack_dly waiting cycles, data three edges later
    always_ff @(posedge clk) begin
        tog_q <= rst ? 1'b0 : ~tog_q;
        if (rst) begin
            cnt_q <= 4'h0;
            done_cnt_q <= 4'h0;
            bus_ack <= 1'b0;
            bus_done <= 1'b0;
            n_reads <= 8'h00;
        end else begin
            bus_ack <= 1'b0;
            bus_done <= 1'b0;
            if (done_cnt_q != 4'h0) begin
                done_cnt_q <= done_cnt_q - 4'h1;
                bus_done <= (done_cnt_q == 4'h1);
            end
            if (bus_req.req && !bus_ack) begin
                if (cnt_q == ack_dly) begin
                    bus_ack <= 1'b1;
                    cnt_q <= 4'h0;
                    n_reads <= n_reads + 8'h01;
                    last_req <= bus_req;
                    done_cnt_q <= 4'h3;
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                end
            end
        end
    end
endmodule : mlp_far_model

// ### tb_top.sv
// Self-checking bench for the execute slice with its far-side model.
// Assumes results show one cycle after the edge that takes an instruction.
`timescale 1ns/1ps
module tb_top;
    import mlp_pkg::*;
    localparam logic [31:0] PHYS = 32'h2000_0000;
    logic clk, rst, instr_valid, load_pending, bus_ack, bus_done;
    logic cfg_ok, cfg_uncached, cfg_hit;
    logic [2:0] cfg_cca;
    logic [3:0] ack_dly;
    logic [7:0] n_reads;
    logic [31:0] upper_product_reg, bottom_product_reg;
    logic [31:0] gr [32];
    logic signed [63:0] p;
    mlp_instr_t instr;
    mlp_wb_t wb;
    mlp_xlat_req_t xlat_req;
    mlp_xlat_rsp_t xlat_rsp;
    mlp_bus_req_t bus_req, last_req;
    int n_errors, n_checks;

    mlp_exec DUT (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr), .wb(wb),
        .upper_product_reg(upper_product_reg), .bottom_product_reg(bottom_product_reg),
        .xlat_req(xlat_req), .xlat_rsp(xlat_rsp), .load_pending(load_pending),
        .bus_ack(bus_ack), .bus_done(bus_done), .bus_req(bus_req));
    mlp_far_model #(.PHYS_XOR(PHYS)) far (.clk(clk), .rst(rst), .cfg_ok(cfg_ok),
        .cfg_uncached(cfg_uncached), .cfg_hit(cfg_hit), .cfg_cca(cfg_cca), .ack_dly(ack_dly),
        .xlat_req(xlat_req), .xlat_rsp(xlat_rsp), .bus_req(bus_req), .bus_ack(bus_ack),
        .bus_done(bus_done), .n_reads(n_reads), .last_req(last_req));

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    function automatic mlp_instr_t rt_op(input logic [5:0] fn, input logic [4:0] a, b, d, sh);
        return {OPC_SPECIAL, a, b, d, sh, fn};
    endfunction : rt_op

    function automatic mlp_instr_t im_op(input logic [5:0] op, input logic [4:0] a, b,
                                         input logic [15:0] k);
        return {op, a, b, k};
    endfunction : im_op

    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // One instruction, taken at the next edge
    task automatic issue(input mlp_instr_t i);
        @(posedge clk);
        #1 instr_valid = 1'b1;
        instr = i;
        @(posedge clk);
        #1 instr_valid = 1'b0;
    endtask : issue

    // Issue, then judge the writeback one cycle after the taking edge
    task automatic run(input mlp_instr_t i, input logic [4:0] d, input logic [31:0] v,
                       input logic en);
        issue(i);
        @(posedge clk);
        #1 chk("wb valid", wb.valid, en);
        if (en) begin
            chk("wb dest", wb.dest, d);
            chk("wb data", wb.data, v);
            gr[d] = v;
        end
    endtask : run

    task automatic chk_pair(input logic [63:0] e);
        chk("upper", upper_product_reg, e[63:32]);
        chk("bottom", bottom_product_reg, e[31:0]);
    endtask : chk_pair

    task automatic t_logic;
        run(im_op(OPC_EITHER_IMMEDIATE, 0, 1, 16'h8001), 1, 32'h0000_8001, 1);
        run(im_op(OPC_EITHER_IMMEDIATE, 1, 2, 16'h1230), 2, 32'h0000_9231, 1);
        run(rt_op(FN_NEITHER, 2, 0, 3, 0), 3, ~gr[2], 1);
        run(rt_op(FN_EITHER, 3, 1, 4, 0), 4, gr[3] | gr[1], 1);
        run(rt_op(FN_EITHER, 3, 1, 0, 0), 0, 0, 0);
        run(im_op(OPC_EITHER_IMMEDIATE, 1, 0, 16'hffff), 0, 0, 0);
        // Back to back, second one uses the first one's result
        @(posedge clk);
        #1 instr_valid = 1'b1;
        instr = rt_op(FN_EITHER, 2, 1, 5, 0);
        @(posedge clk);
        #1 instr = rt_op(FN_NEITHER, 5, 0, 6, 0);
        @(posedge clk);
        #1 instr_valid = 1'b0;
        chk("wb pair", {wb.valid, wb.dest, wb.data}, {1'b1, 5'h05, gr[2] | gr[1]});
        @(posedge clk);
        #1 chk("wb pair", {wb.valid, wb.dest, wb.data}, {1'b1, 5'h06, ~(gr[2] | gr[1])});
    endtask : t_logic

    task automatic t_products;
        p = $signed(gr[3]) * $signed(gr[2]);
        run(rt_op(FN_SIGNED_PRODUCT, 3, 2, 0, 0), 0, 0, 0);
        chk_pair(p);
        p = {32'h0, gr[3]} * {32'h0, gr[3]};
        run(rt_op(FN_UNSIGNED_PRODUCT, 3, 3, 0, 0), 0, 0, 0);
        chk_pair(p);
        p = $signed(gr[3]) * $signed(gr[1]);
        run({OPC_SECONDARY_GROUP, 5'h03, 5'h01, 5'h07, 5'h00, FN_PRODUCT_TO_DEST}, 7, p[31:0],
            1);
    endtask : t_products

    task automatic t_moves;
        run(rt_op(FN_WRITE_UPPER, 1, 0, 0, 0), 0, 0, 0);
        run(rt_op(FN_WRITE_BOTTOM, 4, 0, 0, 0), 0, 0, 0);
        chk_pair({gr[1], gr[4]});
        run(rt_op(FN_WRITE_UPPER, 3, 0, 0, 5'h01), 0, 0, 0);
        run(32'h0000_0000, 0, 0, 0);
        chk_pair({gr[1], gr[4]});
    endtask : t_moves

    // Prefetch from r4 plus offset; judge translation, bus read and kept state
    task automatic pf(input logic [4:0] h, input logic [15:0] off, input logic exp);
        logic [7:0] n0;
        logic [31:0] va;
        int k;
        n0 = n_reads;
        va = gr[4] + {{16{off[15]}}, off};
        issue(im_op(OPC_CACHE_WARM, 4, h, off));
        k = 0;
        while (xlat_req.valid !== 1'b1 && k < 4) begin
            @(posedge clk);
            #1 k++;
        end
        chk("xlat addr", xlat_req.vaddr, va);
        chk("wb valid", wb.valid, 0);
        repeat (10) @(posedge clk);
        #1 chk("reads", n_reads - n0, exp);
        chk_pair({gr[1], gr[4]});
        if (exp) begin
            chk("bus addr", last_req.addr, va ^ PHYS);
            chk("bus type", {last_req.cca, last_req.for_store}, {cfg_cca, h[0]});
        end
    endtask : pf

    task automatic t_prefetch;
        for (int h = 0; h < 32; h++) begin
            cfg_cca = h[2:0];
            pf(h[4:0], 16'hfff0, h <= 1 || (h >= 4 && h <= 7));
        end
        for (int c = 0; c < 4; c++) begin
            cfg_ok = (c != 0);
            cfg_uncached = (c == 1);
            cfg_hit = (c == 2);
            load_pending = (c == 3);
            pf(HINT_LOAD, 16'h0040, 0);
        end
        cfg_ok = 1'b1;
        cfg_hit = 1'b0;
        load_pending = 1'b0;
    endtask : t_prefetch

    // Slow bus: second prefetch dropped, pipeline keeps going
    task automatic t_busy;
        logic [7:0] n0;
        n0 = n_reads;
        ack_dly = 4'h6;
        issue(im_op(OPC_CACHE_WARM, 4, HINT_STORE, 16'h0000));
        run(rt_op(FN_EITHER, 1, 2, 8, 0), 8, gr[1] | gr[2], 1);
        issue(im_op(OPC_CACHE_WARM, 4, HINT_LOAD, 16'h0100));
        repeat (30) @(posedge clk);
        #1 chk("reads", n_reads - n0, 1);
        chk("bus addr", last_req.addr, gr[4] ^ PHYS);
    endtask : t_busy

    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    // Main sequence
    initial begin
        rst = 1'b1;
        instr_valid = 1'b0;
        instr = '0;
        load_pending = 1'b0;
        {cfg_ok, cfg_uncached, cfg_hit, cfg_cca, ack_dly} = {3'b100, 3'h0, 4'h1};
        gr[0] = 32'h0;
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        chk_pair(64'h0);
        chk("idle outputs", {wb.valid, xlat_req.valid, bus_req.req}, 0);
        t_logic();
        t_products();
        t_moves();
        t_prefetch();
        t_busy();
        end_of_test();
    end

    // Hang guard, well past the expected run length
    initial begin
        repeat (4000) @(posedge clk);
        n_errors++;
        end_of_test();
    end
endmodule : tb_top
